/* File: mgmt_decode_pkg.sv */
// constants and carrier types for the management-RAM decode block
// assumes a single host clock domain and a byte-wide configuration port
package mgmt_decode_pkg;

    // configuration offsets
    localparam logic [7:0] ROW_TIMING_KIND_OFS   = 8'h68;
    localparam logic [7:0] MGMT_RAM_CONTROL_OFS  = 8'h72;
    localparam logic [7:0] ROW_BOUNDARY_OFS0     = 8'h60;

    // reset values
    localparam logic [7:0] ROW_TIMING_KIND_RST   = 8'h00;
    localparam logic [7:0] MGMT_RAM_CONTROL_RST  = 8'h02;
    localparam logic [7:0] ROW_BOUNDARY_RST      = 8'h02;

    // field positions in the control, row kind and row boundary registers
    localparam int OPEN_POS    = 6;
    localparam int CLOSED_POS  = 5;
    localparam int LOCK_POS    = 4;
    localparam int ENABLE_POS  = 3;
    localparam int ROW_TK_MSB  = 4;
    localparam int ROW_BD_MSB  = 5;

    // row geometry
    localparam int NUM_ROWS    = 5;
    localparam int ROW_ADDR_LO = 22;
    localparam int ROW_ADDR_HI = 27;

    // address windows
    localparam logic [31:0] MGMT_SEG_BASE = 32'h000A_0000;
    localparam logic [31:0] MGMT_SEG_LAST = 32'h000B_FFFF;
    localparam logic [31:0] MAIN_MEM_MAX  = 32'h0800_0000;
    localparam logic [7:0]  MAX_ROW_UNITS = 8'h20;

    // routing targets
    typedef enum logic [1:0] {
        TGT_DRAM   = 2'h0,
        TGT_PCI_MEM = 2'h1,
        TGT_PCI_IO = 2'h2
    } target_t;

    // dram timing kind
    typedef enum logic {
        TIMING_PAGE = 1'b0,
        TIMING_EDO  = 1'b1
    } timing_t;

    // host cycle request
    typedef struct packed {
        logic [31:0] addr;
        logic        is_io;
        logic        is_code;
        logic        mgmt_active;
    } host_cycle_t;

    // routing answer
    typedef struct packed {
        target_t                 target;
        logic [NUM_ROWS-1:0]     row_strobe;
        timing_t                 timing;
    } route_t;

    // configuration access
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } cfg_req_t;

endpackage

/* File: cfg_regfile.sv */
// configuration register store for row boundaries, row kinds and control
// assumes writes come one per cycle on the host clock
`timescale 1ns/1ps
module cfg_regfile #(
    parameter int ROWS = 5
) (
    // clock and reset
    input  wire logic                           clk_i,
    input  wire logic                           rst_n_i,
    // access
    input  wire mgmt_decode_pkg::cfg_req_t      req_i,
    output logic [7:0]                          rdata_o,
    // stored values
    output logic [ROWS-1:0]                     row_kind_o,
    output logic [7:0]                          ctrl_o,
    output logic [ROWS*6-1:0]                   bound_o
);
    import mgmt_decode_pkg::*;

    logic [ROWS-1:0]   row_kind_q;
    logic [7:0]        ctrl_q;
    logic [ROWS*6-1:0] bound_q;
    logic [7:0]        rdata_q;

    // row timing kind, reserved bits dropped
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            row_kind_q <= ROWS'(ROW_TIMING_KIND_RST);
        end else if (req_i.wr && req_i.addr == ROW_TIMING_KIND_OFS) begin
            row_kind_q <= req_i.wdata[ROWS-1:0];
        end
    end

    // control register with sticky lock
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctrl_q <= MGMT_RAM_CONTROL_RST;
        end else if (req_i.wr && req_i.addr == MGMT_RAM_CONTROL_OFS) begin
            ctrl_q[CLOSED_POS] <= req_i.wdata[CLOSED_POS];
            ctrl_q[ENABLE_POS] <= req_i.wdata[ENABLE_POS];
            if (!ctrl_q[LOCK_POS]) begin
                ctrl_q[LOCK_POS] <= req_i.wdata[LOCK_POS];
                // setting the lock clears open in the same write
                ctrl_q[OPEN_POS] <= req_i.wdata[OPEN_POS] & ~req_i.wdata[LOCK_POS];
            end
        end
    end

    // row boundary registers
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < ROWS; i++) begin
                bound_q[i*6 +: 6] <= ROW_BOUNDARY_RST[5:0];
            end
        end else begin
            for (int i = 0; i < ROWS; i++) begin
                if (req_i.wr && req_i.addr == ROW_BOUNDARY_OFS0 + 8'(i)) begin
                    bound_q[i*6 +: 6] <= req_i.wdata[ROW_BD_MSB:0];
                end
            end
        end
    end

    // registered read data, unmapped reads as zero
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_q <= 8'h00;
        end else if (req_i.rd) begin
            rdata_q <= 8'h00;
            if (req_i.addr == ROW_TIMING_KIND_OFS) begin
                rdata_q <= 8'(row_kind_q);
            end
            if (req_i.addr == MGMT_RAM_CONTROL_OFS) begin
                rdata_q <= {1'b0, ctrl_q[6:0]};
            end
            for (int i = 0; i < ROWS; i++) begin
                if (req_i.addr == ROW_BOUNDARY_OFS0 + 8'(i)) begin
                    rdata_q <= {2'h0, bound_q[i*6 +: 6]};
                end
            end
        end
    end

    assign rdata_o    = rdata_q;
    assign row_kind_o = row_kind_q;
    assign ctrl_o     = ctrl_q;
    assign bound_o    = bound_q;
endmodule

/* File: mgmt_ram_control_decode_and_row_type.sv */
// host cycle decode with management-RAM visibility and dram row timing kind
// assumes a host cycle is presented for one clock with its strobe
// assumes the management-mode pin is asynchronous and settles two cycles early
`timescale 1ns/1ps
module mgmt_ram_control_decode_and_row_type #(
    parameter int ROWS = 5
) (
    // clock and reset
    input  wire logic                          clk_i,
    input  wire logic                          rst_n_i,
    // configuration port
    input  wire mgmt_decode_pkg::cfg_req_t     cfg_req_i,
    output logic [7:0]                         cfg_rdata_o,
    // host processor cycle
    input  wire logic                          host_addr_strobe_n_i,
    input  wire logic                          mgmt_mode_active_n_i,
    input  wire logic [31:0]                   host_addr_i,
    input  wire logic                          host_is_io_i,
    input  wire logic                          host_is_code_i,
    // pci master access into memory
    input  wire logic                          pci_req_i,
    input  wire logic [31:0]                   pci_addr_i,
    // routing answer
    output logic                               route_valid_o,
    output mgmt_decode_pkg::route_t            route_o,
    output logic                               pci_to_dram_o,
    output logic [ROWS-1:0]                    pci_row_strobe_o,
    // register state
    output logic [7:0]                         mgmt_ram_control_o
);
    import mgmt_decode_pkg::*;

    logic [ROWS-1:0]   row_kind;
    logic [7:0]        ctrl;
    logic [ROWS*6-1:0] bound;
    logic [5:0]        top_units;
    logic              active_sync1_q;
    logic              active_sync2_q;
    host_cycle_t       cyc;
    route_t            route_d;
    route_t            route_q;
    logic              valid_q;
    logic              pci_dram_q;
    logic [ROWS-1:0]   pci_strobe_q;
    logic [7:0]        ctrl_out_q;

    // register store
    cfg_regfile #(
        .ROWS (ROWS)
    ) u_regs (
        .clk_i      (clk_i),
        .rst_n_i    (rst_n_i),
        .req_i      (cfg_req_i),
        .rdata_o    (cfg_rdata_o),
        .row_kind_o (row_kind),
        .ctrl_o     (ctrl),
        .bound_o    (bound)
    );

    // management-mode pin synchroniser
    // only the second flop feeds routing, so a metastable first stage never leaks
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            active_sync1_q <= 1'b0;
            active_sync2_q <= 1'b0;
        end else begin
            active_sync1_q <= ~mgmt_mode_active_n_i;
            active_sync2_q <= active_sync1_q;
        end
    end

    // row select by cumulative boundary compare
    // an empty row repeats the boundary below it, so it never hits
    function automatic logic [ROWS-1:0] row_select(input logic [31:0] a,
                                                   input logic [ROWS*6-1:0] b);
        logic [5:0]      unit;
        logic [5:0]      lower;
        logic [ROWS-1:0] hit;
        unit  = a[ROW_ADDR_HI:ROW_ADDR_LO];
        lower = 6'h00;
        hit   = '0;
        for (int i = 0; i < ROWS; i++) begin
            if (unit >= lower && unit < b[i*6 +: 6]) begin
                hit[i] = 1'b1;
            end
            lower = b[i*6 +: 6];
        end
        return hit;
    endfunction

    // address within populated main memory
    function automatic logic in_main(input logic [31:0] a, input logic [5:0] top);
        return (a < MAIN_MEM_MAX) && (a[31:ROW_ADDR_LO] < 10'(top));
    endfunction

    // host or pci address inside the A and B segments
    function automatic logic in_mgmt_seg(input logic [31:0] a);
        return (a >= MGMT_SEG_BASE) && (a <= MGMT_SEG_LAST);
    endfunction

    // pci master may only reach populated dram outside the management segment
    function automatic logic pci_dram_ok(input logic [31:0] a, input logic [5:0] top);
        return !in_mgmt_seg(a) && in_main(a, top);
    endfunction

    // visibility of management dram for one host cycle
    // invalid open plus closed resolves to pci before the open test
    function automatic logic mgmt_visible(input logic [7:0] c, input logic act,
                                          input logic code);
        logic vis;
        vis = 1'b0;
        if (!c[ENABLE_POS]) begin
            vis = 1'b0;
        end else if (!c[LOCK_POS] && c[OPEN_POS] && c[CLOSED_POS]) begin
            vis = 1'b0;
        end else if (!c[LOCK_POS] && c[OPEN_POS]) begin
            vis = 1'b1;
        end else if (!act) begin
            vis = 1'b0;
        end else if (c[CLOSED_POS]) begin
            vis = code;
        end else begin
            vis = 1'b1;
        end
        return vis;
    endfunction

    // assemble the cycle
    assign cyc.addr        = host_addr_i;
    assign cyc.is_io       = host_is_io_i;
    assign cyc.is_code     = host_is_code_i;
    assign cyc.mgmt_active = active_sync2_q;

    // top of populated memory is the last cumulative boundary
    assign top_units = bound[(ROWS-1)*6 +: 6];

    // route decision
    always_comb begin
        route_d.row_strobe = '0;
        route_d.timing     = TIMING_PAGE;
        // io cycles never reach memory whatever the address
        if (cyc.is_io) begin
            route_d.target = TGT_PCI_IO;
        end else if (in_mgmt_seg(cyc.addr)) begin
            if (mgmt_visible(ctrl, cyc.mgmt_active, cyc.is_code)) begin
                route_d.target = TGT_DRAM;
            end else begin
                route_d.target = TGT_PCI_MEM;
            end
        end else if (in_main(cyc.addr, top_units)) begin
            route_d.target = TGT_DRAM;
        end else begin
            route_d.target = TGT_PCI_MEM;
        end
        if (route_d.target == TGT_DRAM) begin
            route_d.row_strobe = row_select(cyc.addr, bound);
            route_d.timing = timing_t'(|(route_d.row_strobe & row_kind));
        end
    end

    // registered host answer, one cycle after the strobe
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            valid_q <= 1'b0;
            route_q <= '0;
        end else begin
            valid_q <= ~host_addr_strobe_n_i;
            if (!host_addr_strobe_n_i) begin
                route_q <= route_d;
            end
        end
    end

    // pci master accesses never see management dram
    // the strobe shares the test, so no row fires for a refused or unpopulated access
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pci_dram_q   <= 1'b0;
            pci_strobe_q <= '0;
        end else if (pci_req_i && pci_dram_ok(pci_addr_i, top_units)) begin
            pci_dram_q   <= 1'b1;
            pci_strobe_q <= row_select(pci_addr_i, bound);
        end else begin
            pci_dram_q   <= 1'b0;
            pci_strobe_q <= '0;
        end
    end

    // control register mirror
    // lags the register by one cycle, in step with the registered route
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctrl_out_q <= MGMT_RAM_CONTROL_RST;
        end else begin
            ctrl_out_q <= ctrl;
        end
    end

    assign route_valid_o      = valid_q;
    assign route_o            = route_q;
    assign pci_to_dram_o      = pci_dram_q;
    assign pci_row_strobe_o   = pci_strobe_q;
    assign mgmt_ram_control_o = ctrl_out_q;
endmodule

/* File: mgmt_ram_control_chk.sv */
// checker for host routing and control-register invariants
// assumes one host clock and registered answers one cycle after the request
`timescale 1ns/1ps
module mgmt_ram_control_chk #(
    parameter int ROWS = 5
) (
    // clock and reset
    input wire logic                    clk_i,
    input wire logic                    rst_n_i,
    // requests
    input wire logic                    host_addr_strobe_n_i,
    input wire logic [31:0]             host_addr_i,
    input wire logic                    host_is_io_i,
    input wire logic                    host_is_code_i,
    input wire logic                    pci_req_i,
    input wire logic [31:0]             pci_addr_i,
    // answers
    input wire logic                    route_valid_o,
    input wire mgmt_decode_pkg::route_t route_o,
    input wire logic                    pci_to_dram_o,
    input wire logic [ROWS-1:0]         pci_row_strobe_o,
    input wire logic [7:0]              mgmt_ram_control_o
);
    import mgmt_decode_pkg::*;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // host memory cycle into the management segment
    sequence seg_cyc;
        !host_addr_strobe_n_i && !host_is_io_i
            && host_addr_i >= MGMT_SEG_BASE && host_addr_i <= MGMT_SEG_LAST;
    endsequence
    // pci master request into the management segment
    sequence pci_seg;
        pci_req_i && pci_addr_i >= MGMT_SEG_BASE && pci_addr_i <= MGMT_SEG_LAST;
    endsequence
    // the control copy one cycle later shows the value the routing used
    strobe_answer_a: assert property (!host_addr_strobe_n_i |=> route_valid_o)
        else $error("no answer after host strobe");
    answer_cause_a: assert property (route_valid_o |-> $past(!host_addr_strobe_n_i))
        else $error("answer without host strobe");
    io_target_a: assert property (!host_addr_strobe_n_i && host_is_io_i |=>
        route_o.target == TGT_PCI_IO) else $error("io cycle not sent to pci io");
    disabled_pci_a: assert property (seg_cyc |=>
        mgmt_ram_control_o[3] || route_o.target == TGT_PCI_MEM)
        else $error("disabled segment not sent to pci");
    closed_data_a: assert property (seg_cyc ##0 !host_is_code_i |=>
        !(mgmt_ram_control_o[3] && mgmt_ram_control_o[5]) || route_o.target == TGT_PCI_MEM)
        else $error("closed data reference reached dram");
    pci_no_dram_a: assert property (pci_seg |=> !pci_to_dram_o)
        else $error("pci master reached segment dram");
    pci_no_row_a: assert property (pci_seg |=> pci_row_strobe_o == '0)
        else $error("row strobe for pci segment access");
    lock_sticky_a: assert property (mgmt_ram_control_o[4] |=> mgmt_ram_control_o[4])
        else $error("lock cleared without reset");
    lock_open_a: assert property (mgmt_ram_control_o[4] |-> !mgmt_ram_control_o[6])
        else $error("open set while locked");
endmodule
bind mgmt_ram_control_decode_and_row_type mgmt_ram_control_chk #(.ROWS(ROWS)) i_chk (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .host_addr_strobe_n_i(host_addr_strobe_n_i),
    .host_addr_i(host_addr_i), .host_is_io_i(host_is_io_i), .host_is_code_i(host_is_code_i),
    .pci_req_i(pci_req_i), .pci_addr_i(pci_addr_i), .route_valid_o(route_valid_o),
    .route_o(route_o), .pci_to_dram_o(pci_to_dram_o), .pci_row_strobe_o(pci_row_strobe_o),
    .mgmt_ram_control_o(mgmt_ram_control_o)
);

/* File: host_bus_model.sv */
// host processor bus model issuing single code, data and io cycles
// assumes the block samples the strobe on the rising host clock
`timescale 1ns/1ps
module host_bus_model (
    // clock
    input  wire logic   clk_i,
    // host bus pins
    output logic        host_addr_strobe_n_o,
    output logic        mgmt_mode_active_n_o,
    output logic [31:0] host_addr_o,
    output logic        host_is_io_o,
    output logic        host_is_code_o
);
    // idle bus from time zero
    initial begin
        host_addr_strobe_n_o = 1'b1;
        mgmt_mode_active_n_o = 1'b1;
        host_addr_o = 32'h0000_0000;
        host_is_io_o = 1'b0;
        host_is_code_o = 1'b0;
    end
    // mode level first, settled through the synchroniser, then a one-cycle strobe
    task automatic issue(input logic [31:0] a, input logic io, input logic code,
                         input logic act_n);
        @(negedge clk_i);
        mgmt_mode_active_n_o = act_n;
        repeat (3) @(negedge clk_i);
        host_addr_strobe_n_o = 1'b0;
        host_addr_o = a;
        host_is_io_o = io;
        host_is_code_o = code;
        @(negedge clk_i);
        host_addr_strobe_n_o = 1'b1;
        host_addr_o = ~a; // released lines lose their value
        host_is_io_o = ~io;
        host_is_code_o = ~code;
    endtask
endmodule

/* File: mgmt_ram_control_decode_and_row_type_tb.sv */
// self-checking bench for the management-RAM decode block
// assumes the host model issues cycles; this bench drives config and pci
`timescale 1ns/1ps
module mgmt_ram_control_decode_and_row_type_tb;
    import mgmt_decode_pkg::*;
    logic        clk_i = 1'b0;
    logic        rst_n_i = 1'b0;
    cfg_req_t    cfg_req = '0;
    logic        pci_req = 1'b0;
    logic [31:0] pci_addr = '0;
    logic        strobe_n, act_n, is_io, is_code, valid, to_dram;
    logic [31:0] haddr;
    logic [7:0]  rdata, ctrl;
    logic [4:0]  prow;
    route_t      route;
    int          n_mismatch = 0;
    int          samples_checked = 0;
    // control value, mode level, code flag, expected target
    logic [11:0] tab [8] = '{12'h025, 12'h429, 12'h0A0, 12'h0AD,
                             12'h4A8, 12'h2A4, 12'h2A1, 12'h6A5};
    // 10 MHz host clock
    always #50 clk_i = ~clk_i;
    host_bus_model i_host (.clk_i(clk_i), .host_addr_strobe_n_o(strobe_n),
        .mgmt_mode_active_n_o(act_n), .host_addr_o(haddr), .host_is_io_o(is_io),
        .host_is_code_o(is_code));
    mgmt_ram_control_decode_and_row_type #(.ROWS(5)) i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .cfg_req_i(cfg_req), .cfg_rdata_o(rdata), .host_addr_strobe_n_i(strobe_n),
        .mgmt_mode_active_n_i(act_n), .host_addr_i(haddr), .host_is_io_i(is_io),
        .host_is_code_i(is_code), .pci_req_i(pci_req), .pci_addr_i(pci_addr),
        .route_valid_o(valid), .route_o(route), .pci_to_dram_o(to_dram),
        .pci_row_strobe_o(prow), .mgmt_ram_control_o(ctrl));
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic end_sim();
        $display("mismatches=%0d checks=%0d", n_mismatch, samples_checked);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic cfg_wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_i);
        cfg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(negedge clk_i);
        cfg_req = '0;
    endtask
    task automatic cfg_rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge clk_i);
        cfg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(negedge clk_i);
        cfg_req = '0;
        check(rdata, e);
    endtask
    task automatic host(input logic [31:0] a, input logic io, input logic code,
                        input logic an, input logic [1:0] tgt);
        i_host.issue(a, io, code, an);
        check({7'h00, valid}, 8'h01);
        check({6'h00, route.target}, {6'h00, tgt});
    endtask
    task automatic t_pci(input logic [31:0] a, input logic [7:0] ed, input logic [7:0] er);
        @(negedge clk_i);
        pci_req = 1'b1;
        pci_addr = a;
        @(negedge clk_i);
        pci_req = 1'b0;
        pci_addr = ~a;
        check({7'h00, to_dram}, ed);
        check({3'h0, prow}, er);
    endtask
    task automatic t_reset();
        cfg_rd(ROW_TIMING_KIND_OFS, 8'h00);
        cfg_rd(MGMT_RAM_CONTROL_OFS, 8'h02);
        cfg_rd(8'h7F, 8'h00);
        cfg_rd(ROW_BOUNDARY_OFS0, 8'h02);
        check(ctrl, 8'h02);
    endtask
    task automatic t_rows();
        for (int i = 1; i < 5; i++) begin
            cfg_wr(ROW_BOUNDARY_OFS0 + 8'(i), 8'h04);
        end
        cfg_rd(ROW_BOUNDARY_OFS0 + 8'h04, 8'h04);
        cfg_wr(ROW_TIMING_KIND_OFS, 8'hFF);
        cfg_rd(ROW_TIMING_KIND_OFS, 8'h1F);
        host(32'h0010_0000, 1'b0, 1'b0, 1'b1, TGT_DRAM);
        check({7'h00, route.timing}, 8'h01);
        cfg_wr(ROW_TIMING_KIND_OFS, 8'h1E);
        host(32'h0010_0000, 1'b0, 1'b1, 1'b1, TGT_DRAM);
        check({3'h0, route.row_strobe}, 8'h01);
        check({7'h00, route.timing}, 8'h00);
        host(32'h0080_0000, 1'b0, 1'b0, 1'b1, TGT_DRAM);
        check({3'h0, route.row_strobe}, 8'h02);
        check({7'h00, route.timing}, 8'h01);
        host(32'h0100_0000, 1'b0, 1'b0, 1'b1, TGT_PCI_MEM);
        host(32'h0000_03F8, 1'b1, 1'b0, 1'b1, TGT_PCI_IO);
    endtask
    task automatic t_table();
        for (int i = 0; i < 8; i++) begin
            cfg_wr(MGMT_RAM_CONTROL_OFS, tab[i][11:4]);
            host(i[0] ? 32'h000B_FFF0 : 32'h000A_0000, 1'b0, tab[i][2], tab[i][3],
                 tab[i][1:0]);
        end
    endtask
    task automatic t_lock();
        cfg_wr(MGMT_RAM_CONTROL_OFS, 8'h0A);
        cfg_wr(MGMT_RAM_CONTROL_OFS, 8'h1A);
        cfg_wr(MGMT_RAM_CONTROL_OFS, 8'h5A);
        cfg_rd(MGMT_RAM_CONTROL_OFS, 8'h1A);
        cfg_wr(MGMT_RAM_CONTROL_OFS, 8'h6A);
        cfg_rd(MGMT_RAM_CONTROL_OFS, 8'h3A);
        host(32'h000A_0000, 1'b0, 1'b0, 1'b1, TGT_PCI_MEM);
        host(32'h000A_0000, 1'b0, 1'b1, 1'b0, TGT_DRAM);
        host(32'h000A_0000, 1'b0, 1'b0, 1'b0, TGT_PCI_MEM);
        check(ctrl, 8'h3A);
        @(negedge clk_i);
        rst_n_i = 1'b0;
        repeat (2) @(negedge clk_i);
        rst_n_i = 1'b1;
        cfg_rd(MGMT_RAM_CONTROL_OFS, 8'h02);
    endtask
    // main sequence
    initial begin
        repeat (20) @(negedge clk_i);
        rst_n_i = 1'b1;
        t_reset();
        t_rows();
        t_table();
        cfg_wr(MGMT_RAM_CONTROL_OFS, 8'h4A);
        t_pci(32'h000A_8000, 8'h00, 8'h00);
        t_pci(32'h0080_0000, 8'h01, 8'h02);
        t_lock();
        end_sim();
    end
    // watchdog against a hung run
    initial begin
        #1000000;
        n_mismatch++;
        end_sim();
    end
endmodule
